// ### core/sdc_defines.svh
`ifndef SDC_DEFINES_SVH
`define SDC_DEFINES_SVH
// register byte offsets
`define SDC_OFF_RATIO 12'h000
`define SDC_OFF_BURST 12'h004
`define SDC_OFF_CTRL 12'h008
`define SDC_OFF_NOTCH 12'h00c
`define SDC_OFF_CMD 12'h010
`define SDC_OFF_STATUS 12'h014
`define SDC_OFF_FMT0 12'h018
`define SDC_OFF_FMT1 12'h01c
`define SDC_OFF_FMT2 12'h020
// field positions in the control word
`define SDC_CTRL_TDC_LSB 0
`define SDC_CTRL_IMM_BIT 2
`define SDC_CTRL_FAIR_LSB 4
`define SDC_CTRL_PRIV_BIT 8
// encodings
`define SDC_TDC_OFF 2'b00
`define SDC_TDC_DATA 2'b01
`define SDC_TDC_RSVD 2'b10
`define SDC_TDC_CMD 2'b11
`define SDC_OP_READ6 8'h08
`define SDC_OP_READ10 8'h28
`define SDC_OP_WRITE6 8'h0a
`define SDC_OP_WRITE10 8'h2a
`define SDC_OP_WRVFY 8'h2e
`define SDC_RATIO_DEN_SH 8
`define SDC_NOTCHES 16
`define SDC_BLOCK_BYTES 16'h0200
// sense answer for an illegal field
`define SDC_SENSE_KEY 4'h5
`define SDC_SENSE_ASC 8'h26
// fixed format flags: soft, hard, removable, surface
`define SDC_FMT_FLAGS 4'b0100
`endif

// ### core/sdc_pkg.sv
package sdc_pkg;
    typedef enum logic [2:0] {
        SDC_IDLE = 3'b000,
        SDC_CMD = 3'b001,
        SDC_XFER = 3'b011,
        SDC_DISC = 3'b010,
        SDC_WAIT = 3'b110,
        SDC_HOLD = 3'b111
    } sdc_state_t;
endpackage : sdc_pkg

// ### core/sdc_disconnect_ctrl.sv
// Register access over APB and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "sdc_defines.svh"
// Notes on behaviour
// - reads reconnect once buffer fill reaches read ratio over 256
// - writes reconnect once buffer emptiness reaches write ratio over 256
// - a zero ratio is replaced by an optimal ratio from transfer rate
// - burst limit counts whole blocks
// - disconnect only at a block boundary
// - a burst shorter than one block still moves one whole block
// - burst value zero means no limit per connection
// - with privilege, disconnect on empty buffer in reads or full buffer in writes
// - burst limit applies only when disconnect privilege is granted
// - immediate flag with privilege forces disconnect after command, before data
// - immediate flag clear lets data start right after command
// - never disconnect while a priority command runs
// - control 00b defers to other fields, 10b is reserved
// - control 01b holds the bus once data starts, until all data has moved
// - control 11b holds the bus once data starts, until the command completes
// - nonzero control with nonzero burst gives illegal request check
// - fair arbitration used whenever its field is nonzero
// - ratio pair kept per notch; notch zero writes all notches
// - policy governs read 08h/28h and write 0ah/2ah/2eh only
// - format parameters are read only and follow active notch; code returns the zone inputs directly, with no select by notch_r
// - format flags read soft 0, hard 1, removable 0, surface 0
module sdc_disconnect_ctrl (
    input wire logic I_CLK,
    input wire logic I_SYS_RST,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [11:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    output logic [31:0] O_PRDATA,
    input wire logic i_cmd_valid,
    input wire logic [7:0] i_cmd_opcode,
    input wire logic i_cmd_priority,
    input wire logic i_block_done,
    input wire logic i_data_done,
    input wire logic i_cmd_done,
    input wire logic i_disc_rejected,
    input wire logic [7:0] i_buf_level,
    input wire logic [7:0] i_opt_read_ratio,
    input wire logic [7:0] i_opt_write_ratio,
    input wire logic [15:0] i_zone_tracks,
    input wire logic [15:0] i_zone_sectors,
    input wire logic [15:0] i_zone_track_skew,
    input wire logic [15:0] i_zone_cyl_skew,
    output logic O_DATA_PHASE,
    output logic O_DISCONNECT_REQ,
    output logic O_RECONNECT_REQ,
    output logic O_FAIR_ARB,
    output logic O_CHECK_COND,
    output logic [3:0] O_SENSE_KEY,
    output logic [7:0] O_SENSE_ASC
);
    sdc_pkg::sdc_state_t state_r;
    logic [7:0] rd_ratio_r [0:`SDC_NOTCHES-1];
    logic [7:0] wr_ratio_r [0:`SDC_NOTCHES-1];
    logic [15:0] burst_r;
    logic [1:0] tdc_r;
    logic imm_r;
    logic [2:0] fair_r;
    logic priv_r;
    logic [3:0] notch_r;
    logic is_read_r;
    logic [15:0] blk_cnt_r;
    logic is_wr;
    logic is_rd;
    logic apb_go;
    logic [7:0] rd_thr;
    logic [7:0] wr_thr;
    logic policy_op;
    logic burst_hit;
    logic buf_limit;
    logic hold_bus;
    logic reconnect_ok;
    integer n;

    // effective threshold: zero falls back to the optimal value
    function automatic logic [7:0] pick_ratio(input logic [7:0] prog, input logic [7:0] opt);
        pick_ratio = (prog == 8'h00) ? opt : prog;
    endfunction : pick_ratio

    // nonzero transfer control together with a burst limit is an illegal pair
    function automatic logic bad_cfg(input logic [1:0] tdc, input logic [15:0] burst);
        bad_cfg = (tdc != `SDC_TDC_OFF) && (burst != 16'h0000);
    endfunction : bad_cfg

    // read opcodes among those that obey the policy
    function automatic logic rd_op(input logic [7:0] op);
        rd_op = (op == `SDC_OP_READ6) || (op == `SDC_OP_READ10);
    endfunction : rd_op

    assign apb_go = I_PSEL && I_PENABLE && O_PREADY;
    assign is_wr = apb_go && I_PWRITE;
    assign is_rd = apb_go && !I_PWRITE;
    assign rd_thr = pick_ratio(rd_ratio_r[notch_r], i_opt_read_ratio);
    assign wr_thr = pick_ratio(wr_ratio_r[notch_r], i_opt_write_ratio);
    // recognise the read and write opcodes that obey the policy
    assign policy_op = rd_op(i_cmd_opcode) ||
        (i_cmd_opcode == `SDC_OP_WRITE6) || (i_cmd_opcode == `SDC_OP_WRITE10) ||
        (i_cmd_opcode == `SDC_OP_WRVFY);
    // burst counted in blocks, tested only at a block boundary, zero is unlimited
    assign burst_hit = priv_r && (burst_r != 16'h0000) && i_block_done &&
        (blk_cnt_r + 16'h0001 >= burst_r);
    // read drains the segment, write fills it
    assign buf_limit = i_block_done && (is_read_r ? (i_buf_level == 8'h00) : (i_buf_level == 8'hff));
    assign hold_bus = i_cmd_priority || (tdc_r == `SDC_TDC_DATA) || (tdc_r == `SDC_TDC_CMD);
    // ratio over 256: compare the level byte with the numerator
    assign reconnect_ok = is_read_r ? (i_buf_level >= rd_thr) :
        ((8'hff - i_buf_level) >= wr_thr);

    // apb always answers in the access cycle
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            O_PREADY <= 1'b0;
        end else begin
            O_PREADY <= I_PSEL && !I_PENABLE;
        end
    end

    // apb read mux and error on unmapped or read-only write
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            O_PRDATA <= 32'h0000_0000;
            O_PSLVERR <= 1'b0;
        end else if (I_PSEL && !I_PENABLE) begin
            O_PSLVERR <= 1'b0;
            O_PRDATA <= 32'h0000_0000;
            case (I_PADDR)
                `SDC_OFF_RATIO: O_PRDATA <= {16'h0000, wr_ratio_r[notch_r], rd_ratio_r[notch_r]};
                `SDC_OFF_BURST: O_PRDATA <= {16'h0000, burst_r};
                `SDC_OFF_CTRL: O_PRDATA <= {23'h000000, priv_r, 1'b0, fair_r, 1'b0, imm_r, tdc_r};
                `SDC_OFF_NOTCH: O_PRDATA <= {28'h0000000, notch_r};
                `SDC_OFF_CMD: O_PRDATA <= 32'h0000_0000;
                `SDC_OFF_STATUS: O_PRDATA <= {25'h0000000, O_CHECK_COND, O_RECONNECT_REQ,
                    O_DISCONNECT_REQ, O_DATA_PHASE, state_r};
                `SDC_OFF_FMT0: O_PRDATA <= {i_zone_tracks, i_zone_sectors};
                `SDC_OFF_FMT1: O_PRDATA <= {i_zone_track_skew, i_zone_cyl_skew};
                `SDC_OFF_FMT2: O_PRDATA <= {`SDC_BLOCK_BYTES, 12'h000, `SDC_FMT_FLAGS};
                default: O_PSLVERR <= 1'b1;
            endcase
            if (I_PWRITE && (I_PADDR == `SDC_OFF_STATUS || I_PADDR >= `SDC_OFF_FMT0)) begin
                O_PSLVERR <= 1'b1;
            end
        end
    end

    // per-notch ratio tables; notch zero broadcasts to every notch
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            for (n = 0; n < `SDC_NOTCHES; n = n + 1) begin
                rd_ratio_r[n] <= 8'h00;
                wr_ratio_r[n] <= 8'h00;
            end
        end else if (is_wr && I_PADDR == `SDC_OFF_RATIO) begin
            for (n = 0; n < `SDC_NOTCHES; n = n + 1) begin
                if (notch_r == 4'h0 || n[3:0] == notch_r) begin
                    rd_ratio_r[n] <= I_PWDATA[7:0];
                    wr_ratio_r[n] <= I_PWDATA[15:8];
                end
            end
        end
    end

    // configuration registers
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            burst_r <= 16'h0000;
            tdc_r <= `SDC_TDC_OFF;
            imm_r <= 1'b0;
            fair_r <= 3'b000;
            priv_r <= 1'b0;
            notch_r <= 4'h0;
        end else if (is_wr) begin
            if (I_PADDR == `SDC_OFF_BURST) begin
                burst_r <= I_PWDATA[15:0];
            end
            if (I_PADDR == `SDC_OFF_CTRL) begin
                // reserved control value is not accepted
                if (I_PWDATA[`SDC_CTRL_TDC_LSB+:2] != `SDC_TDC_RSVD) begin
                    tdc_r <= I_PWDATA[`SDC_CTRL_TDC_LSB+:2];
                end
                imm_r <= I_PWDATA[`SDC_CTRL_IMM_BIT];
                fair_r <= I_PWDATA[`SDC_CTRL_FAIR_LSB+:3];
                priv_r <= I_PWDATA[`SDC_CTRL_PRIV_BIT];
            end
            if (I_PADDR == `SDC_OFF_NOTCH) begin
                notch_r <= I_PWDATA[3:0];
            end
        end
    end

    // fairness follows the field directly
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            O_FAIR_ARB <= 1'b0;
        end else begin
            O_FAIR_ARB <= (fair_r != 3'b000);
        end
    end

    // illegal field combination; new detection wins over clear by command write
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            O_CHECK_COND <= 1'b0;
            O_SENSE_KEY <= 4'h0;
            O_SENSE_ASC <= 8'h00;
        end else if (i_cmd_valid && bad_cfg(tdc_r, burst_r)) begin
            O_CHECK_COND <= 1'b1;
            O_SENSE_KEY <= `SDC_SENSE_KEY;
            O_SENSE_ASC <= `SDC_SENSE_ASC;
        end else if (is_wr && I_PADDR == `SDC_OFF_CMD && I_PWDATA[0]) begin
            O_CHECK_COND <= 1'b0;
            O_SENSE_KEY <= 4'h0;
            O_SENSE_ASC <= 8'h00;
        end
    end

    // connection state machine
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            state_r <= sdc_pkg::SDC_IDLE;
            is_read_r <= 1'b0;
            blk_cnt_r <= 16'h0000;
            O_DATA_PHASE <= 1'b0;
            O_DISCONNECT_REQ <= 1'b0;
            O_RECONNECT_REQ <= 1'b0;
        end else begin
            O_DISCONNECT_REQ <= 1'b0;
            O_RECONNECT_REQ <= 1'b0;
            case (state_r)
                sdc_pkg::SDC_IDLE: begin
                    if (i_cmd_valid && policy_op && !bad_cfg(tdc_r, burst_r)) begin
                        is_read_r <= rd_op(i_cmd_opcode);
                        blk_cnt_r <= 16'h0000;
                        state_r <= sdc_pkg::SDC_CMD;
                    end
                end
                sdc_pkg::SDC_CMD: begin
                    if (imm_r && priv_r && !i_cmd_priority) begin
                        O_DISCONNECT_REQ <= 1'b1;
                        state_r <= sdc_pkg::SDC_DISC;
                    end else begin
                        O_DATA_PHASE <= 1'b1;
                        state_r <= sdc_pkg::SDC_XFER;
                    end
                end
                sdc_pkg::SDC_XFER: begin
                    if (i_data_done) begin
                        O_DATA_PHASE <= 1'b0;
                        blk_cnt_r <= 16'h0000;
                        state_r <= (tdc_r == `SDC_TDC_CMD) ? sdc_pkg::SDC_HOLD : sdc_pkg::SDC_IDLE;
                    end else if (i_block_done) begin
                        if (!hold_bus && (burst_hit || (priv_r && buf_limit))) begin
                            O_DISCONNECT_REQ <= 1'b1;
                            O_DATA_PHASE <= 1'b0;
                            blk_cnt_r <= 16'h0000;
                            state_r <= sdc_pkg::SDC_DISC;
                        end else begin
                            blk_cnt_r <= blk_cnt_r + 16'h0001;
                        end
                    end
                end
                sdc_pkg::SDC_DISC: begin
                    if (i_disc_rejected) begin
                        O_DATA_PHASE <= 1'b1;
                        state_r <= sdc_pkg::SDC_XFER;
                    end else begin
                        state_r <= sdc_pkg::SDC_WAIT;
                    end
                end
                sdc_pkg::SDC_WAIT: begin
                    if (reconnect_ok) begin
                        O_RECONNECT_REQ <= 1'b1;
                        O_DATA_PHASE <= 1'b1;
                        state_r <= sdc_pkg::SDC_XFER;
                    end
                end
                sdc_pkg::SDC_HOLD: begin
                    if (i_cmd_done) begin
                        state_r <= sdc_pkg::SDC_IDLE;
                    end
                end
                default: state_r <= sdc_pkg::SDC_IDLE;
            endcase
        end
    end

    // checks
    a_prio_no_disc: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (state_r == sdc_pkg::SDC_XFER && i_cmd_priority) |=> !O_DISCONNECT_REQ)
        else $error("disconnect during priority command");
    a_tdc_hold_bus: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (state_r == sdc_pkg::SDC_XFER && tdc_r != `SDC_TDC_OFF) |=> !O_DISCONNECT_REQ)
        else $error("disconnect while transfer control holds bus");
    a_disc_on_block: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (O_DISCONNECT_REQ && $past(state_r) == sdc_pkg::SDC_XFER) |-> $past(i_block_done))
        else $error("disconnect off a block boundary");
    a_unlimited_burst: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (state_r == sdc_pkg::SDC_XFER && burst_r == 16'h0000 && i_buf_level == 8'h80) |=> !O_DISCONNECT_REQ)
        else $error("disconnect with no burst limit");
    a_burst_needs_priv: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (state_r == sdc_pkg::SDC_XFER && !priv_r) |=> !O_DISCONNECT_REQ)
        else $error("disconnect without privilege");
    a_imm_disc: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (state_r == sdc_pkg::SDC_CMD && imm_r && priv_r && !i_cmd_priority) |=> (O_DISCONNECT_REQ && !O_DATA_PHASE))
        else $error("no immediate disconnect");
    a_fair_arb: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        ##1 (O_FAIR_ARB == ($past(fair_r) != 3'b000)))
        else $error("fair arbitration mismatch");
    a_illegal_field: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (i_cmd_valid && tdc_r != `SDC_TDC_OFF && burst_r != 16'h0000) |=> (O_CHECK_COND && O_SENSE_ASC == `SDC_SENSE_ASC))
        else $error("illegal field not reported");
    a_reconnect_thr: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        O_RECONNECT_REQ |-> $past(reconnect_ok))
        else $error("reconnect below threshold");

    // threshold fallback and buffer checks
    a_zero_rd_ratio: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (rd_ratio_r[notch_r] == 8'h00) |-> (rd_thr == i_opt_read_ratio))
        else $error("read ratio fallback");
    a_zero_wr_ratio: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (wr_ratio_r[notch_r] == 8'h00) |-> (wr_thr == i_opt_write_ratio))
        else $error("write ratio fallback");
    a_rd_early_rec: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (state_r == sdc_pkg::SDC_WAIT && is_read_r && i_buf_level < rd_thr)
        |=> !O_RECONNECT_REQ)
        else $error("read reconnect too early");
    a_wr_early_rec: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (state_r == sdc_pkg::SDC_WAIT && !is_read_r && (8'hff - i_buf_level) < wr_thr)
        |=> !O_RECONNECT_REQ)
        else $error("write reconnect too early");
    a_empty_disc: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (state_r == sdc_pkg::SDC_XFER && priv_r && !hold_bus && is_read_r &&
        i_block_done && !i_data_done && i_buf_level == 8'h00) |=> O_DISCONNECT_REQ)
        else $error("no disconnect on empty buffer");

    // command start and hold state checks
    a_cmd_data: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (state_r == sdc_pkg::SDC_CMD && !imm_r) |=> O_DATA_PHASE)
        else $error("no data after command");
    a_prio_no_imm: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (state_r == sdc_pkg::SDC_CMD && i_cmd_priority) |=> !O_DISCONNECT_REQ)
        else $error("priority command disconnected");
    a_other_op: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (state_r == sdc_pkg::SDC_IDLE && i_cmd_valid && !policy_op) |=> (state_r == sdc_pkg::SDC_IDLE))
        else $error("foreign opcode started");
    a_illegal_idle: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (state_r == sdc_pkg::SDC_IDLE && i_cmd_valid && bad_cfg(tdc_r, burst_r))
        |=> (state_r == sdc_pkg::SDC_IDLE))
        else $error("illegal setup started");
    a_hold_bus: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (state_r == sdc_pkg::SDC_HOLD) |-> (!O_DATA_PHASE && !O_DISCONNECT_REQ))
        else $error("bus released in hold");

    // register bus checks
    a_no_rsvd_tdc: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        tdc_r != `SDC_TDC_RSVD)
        else $error("reserved control taken");
    a_fmt_readonly: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (apb_go && I_PWRITE && I_PADDR >= `SDC_OFF_FMT0) |-> O_PSLVERR)
        else $error("format write accepted");
    a_fmt_flags: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (I_PSEL && !I_PENABLE && I_PADDR == `SDC_OFF_FMT2) |=> (O_PRDATA[3:0] == `SDC_FMT_FLAGS))
        else $error("format flags wrong");
    c_burst_disc: cover property (@(posedge I_CLK) disable iff (I_SYS_RST) O_DISCONNECT_REQ && burst_r != 16'h0000);
    c_reconnect: cover property (@(posedge I_CLK) disable iff (I_SYS_RST) O_RECONNECT_REQ);
    c_rejected: cover property (@(posedge I_CLK) disable iff (I_SYS_RST) state_r == sdc_pkg::SDC_DISC && i_disc_rejected);
    c_check: cover property (@(posedge I_CLK) disable iff (I_SYS_RST) O_CHECK_COND);
    c_hold: cover property (@(posedge I_CLK) disable iff (I_SYS_RST) state_r == sdc_pkg::SDC_HOLD);
endmodule : sdc_disconnect_ctrl
`default_nettype wire

// ### sim/sdc_init_model.sv
`timescale 1ns/1ps
`default_nettype none
// initiator model: takes or refuses disconnect requests and tallies bus events
module sdc_init_model (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_disc_req,
    input wire logic i_rec_req,
    input wire logic i_refuse,
    output logic o_rejected,
    output int o_n_disc,
    output int o_n_rec
);
    // refusal answers while the disconnect request stands
    assign o_rejected = i_disc_req & i_refuse;
    // count disconnect and reselection requests seen on the bus
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_n_disc <= 0;
            o_n_rec <= 0;
        end else begin
            o_n_disc <= o_n_disc + (i_disc_req ? 1 : 0);
            o_n_rec <= o_n_rec + (i_rec_req ? 1 : 0);
        end
    end
endmodule : sdc_init_model
`default_nettype wire

// ### sim/scsi_target_disconnect_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("FAIL %s exp %0h got %0h", nm, e, g); end end
`define PULSE(s) begin s <= 1'b1; @(posedge clk); s <= 1'b0; @(posedge clk); end
module scsi_target_disconnect_control_tb;
    typedef struct packed {
        logic w;
        logic [11:0] a;
        logic [31:0] d;
        logic [31:0] m;
        logic [31:0] e;
        logic er;
    } sdc_row_t;
    localparam int NR = 23;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, cval = 1'b0, prio = 1'b0;
    logic blk = 1'b0, ddone = 1'b0, cdone = 1'b0, refuse = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [7:0] op = 8'h00, lvl = 8'h40, optr = 8'h20, optw = 8'h40;
    logic [15:0] ztr = 16'h1234, zse = 16'h0056, ztsk = 16'h0007, zcsk = 16'h0003;
    logic pready, pslverr, er, rej, dphase, dreq, rreq, fair, chk;
    logic [31:0] prdata, rd;
    logic [3:0] skey;
    logic [7:0] sasc;
    int num_errors = 0, n_checks = 0, n_disc, n_rec, k;
    logic [7:0] ops [5] = '{8'h08, 8'h28, 8'h0a, 8'h2a, 8'h2e};
    // register accesses: write, addr, data, read mask, expected read, expected error
    sdc_row_t rows [NR] = '{
        '{1'b0, 12'h008, 32'h0, 32'hffffffff, 32'h0, 1'b0},
        '{1'b0, 12'h004, 32'h0, 32'h0000ffff, 32'h0, 1'b0},
        '{1'b0, 12'h020, 32'h0, 32'hffff000f, 32'h02000004, 1'b0},
        '{1'b0, 12'h018, 32'h0, 32'hffffffff, 32'h12340056, 1'b0},
        '{1'b0, 12'h01c, 32'h0, 32'hffffffff, 32'h00070003, 1'b0},
        '{1'b1, 12'h018, 32'hffffffff, 32'h0, 32'h0, 1'b1},
        '{1'b1, 12'h020, 32'h0, 32'h0, 32'h0, 1'b1},
        '{1'b0, 12'h018, 32'h0, 32'hffffffff, 32'h12340056, 1'b0},
        '{1'b1, 12'h014, 32'h0, 32'h0, 32'h0, 1'b1},
        '{1'b1, 12'h100, 32'h0, 32'h0, 32'h0, 1'b1},
        '{1'b0, 12'h100, 32'h0, 32'h0, 32'h0, 1'b1},
        '{1'b1, 12'h008, 32'h1, 32'h0, 32'h0, 1'b0},
        '{1'b1, 12'h008, 32'h2, 32'h0, 32'h0, 1'bx},
        '{1'b0, 12'h008, 32'h0, 32'h3, 32'h1, 1'b0},
        '{1'b1, 12'h008, 32'h0, 32'h0, 32'h0, 1'b0},
        '{1'b1, 12'h00c, 32'h0, 32'h0, 32'h0, 1'b0},
        '{1'b1, 12'h000, 32'h0, 32'h0, 32'h0, 1'b0},
        '{1'b1, 12'h00c, 32'h3, 32'h0, 32'h0, 1'b0},
        '{1'b1, 12'h000, 32'h1020, 32'h0, 32'h0, 1'b0},
        '{1'b0, 12'h000, 32'h0, 32'hffff, 32'h1020, 1'b0},
        '{1'b1, 12'h00c, 32'h5, 32'h0, 32'h0, 1'b0},
        '{1'b0, 12'h000, 32'h0, 32'hffff, 32'h0, 1'b0},
        '{1'b1, 12'h004, 32'h2, 32'h0, 32'h0, 1'b0}
    };
    sdc_disconnect_ctrl dut (.I_CLK(clk), .I_SYS_RST(rst), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
        .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .O_PRDATA(prdata),
        .i_cmd_valid(cval), .i_cmd_opcode(op), .i_cmd_priority(prio), .i_block_done(blk), .i_data_done(ddone),
        .i_cmd_done(cdone), .i_disc_rejected(rej), .i_buf_level(lvl), .i_opt_read_ratio(optr),
        .i_opt_write_ratio(optw), .i_zone_tracks(ztr), .i_zone_sectors(zse), .i_zone_track_skew(ztsk),
        .i_zone_cyl_skew(zcsk), .O_DATA_PHASE(dphase), .O_DISCONNECT_REQ(dreq), .O_RECONNECT_REQ(rreq),
        .O_FAIR_ARB(fair), .O_CHECK_COND(chk), .O_SENSE_KEY(skey), .O_SENSE_ASC(sasc));
    sdc_init_model u_init (.i_clk(clk), .i_rst(rst), .i_disc_req(dreq), .i_rec_req(rreq), .i_refuse(refuse),
        .o_rejected(rej), .o_n_disc(n_disc), .o_n_rec(n_rec));
    // free-running bus clock
    initial begin
        forever #50 clk = ~clk;
    end
    task automatic summarize;
        if (num_errors == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : summarize
    // cuts a hang short well beyond the expected run length
    initial begin
        #(4000 * 100);
        num_errors++;
        summarize();
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    // one apb transfer: setup, then access held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
        output logic e);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rd, er);
    endtask : wr
    task automatic cmd(input logic [7:0] o);
        op <= o;
        `PULSE(cval)
    endtask : cmd
    // bounded wait for the data phase flag to reach a level
    task automatic wdp(input logic v);
        for (k = 0; k < 30 && dphase !== v; k++) @(posedge clk);
        `CHK("data_phase", v, dphase)
    endtask : wdp
    task automatic finish_cmd;
        `PULSE(ddone)
        wdp(1'b0);
        `PULSE(cdone)
        tick(2);
    endtask : finish_cmd
    initial begin
        tick(12);
        rst <= 1'b0;
        tick(1);
        // register table walk
        for (int i = 0; i < NR; i++) begin
            apb(rows[i].w, rows[i].a, rows[i].d, rd, er);
            if (!rows[i].w) `CHK("rdata", rows[i].e & rows[i].m, rd & rows[i].m)
            if (rows[i].er !== 1'bx) `CHK("pslverr", rows[i].er, er)
        end
        for (int f = 0; f < 8; f++) begin
            wr(12'h008, 32'h100 | (32'(f) << 4));
            tick(2);
            `CHK("fair_arb", (f != 0), fair)
        end
        // burst of two blocks, then reconnect on the optimal read ratio
        wr(12'h008, 32'h100);
        lvl <= 8'h10;
        cmd(8'h08);
        wdp(1'b1);
        tick(5);
        `CHK("disc_mid_block", 0, n_disc)
        `PULSE(blk)
        tick(3);
        `CHK("disc_one_block", 0, n_disc)
        `PULSE(blk)
        tick(3);
        `CHK("disc_burst", 1, n_disc)
        `CHK("dphase_off", 1'b0, dphase)
        tick(5);
        `CHK("rec_below_ratio", 0, n_rec)
        lvl <= 8'h20;
        wdp(1'b1);
        tick(2);
        `CHK("rec_at_ratio", 1, n_rec)
        finish_cmd();
        // immediate disconnect on a write, reconnect on the optimal write ratio
        wr(12'h004, 32'h0);
        wr(12'h008, 32'h104);
        lvl <= 8'hf0;
        cmd(8'h2a);
        tick(4);
        `CHK("imm_disc", 2, n_disc)
        `CHK("imm_no_data", 1'b0, dphase)
        tick(4);
        `CHK("wr_rec_low", 1, n_rec)
        lvl <= 8'h80;
        wdp(1'b1);
        finish_cmd();
        prio <= 1'b1;
        cmd(8'h28);
        wdp(1'b1);
        `CHK("prio_no_disc", 2, n_disc)
        finish_cmd();
        prio <= 1'b0;
        // no privilege: burst limit is not applied
        wr(12'h008, 32'h0);
        wr(12'h004, 32'h1);
        cmd(8'h0a);
        wdp(1'b1);
        `PULSE(blk)
        tick(3);
        `CHK("no_priv_disc", 2, n_disc)
        finish_cmd();
        // unlimited burst, then an empty buffer at a boundary
        wr(12'h004, 32'h0);
        wr(12'h008, 32'h100);
        lvl <= 8'h40;
        cmd(8'h08);
        wdp(1'b1);
        repeat (3) `PULSE(blk)
        tick(2);
        `CHK("no_limit", 2, n_disc)
        lvl <= 8'h00;
        `PULSE(blk)
        tick(3);
        `CHK("empty_disc", 3, n_disc)
        lvl <= 8'h40;
        wdp(1'b1);
        finish_cmd();
        // initiator refuses the disconnect: transfer carries on
        wr(12'h004, 32'h1);
        refuse <= 1'b1;
        cmd(8'h08);
        wdp(1'b1);
        `PULSE(blk)
        tick(4);
        `CHK("rej_disc", 4, n_disc)
        `CHK("rej_stay", 1'b1, dphase)
        `CHK("rej_no_rec", 3, n_rec)
        refuse <= 1'b0;
        finish_cmd();
        wr(12'h004, 32'h0);
        // empty buffer at boundaries: only the transfer control keeps the bus
        lvl <= 8'h00;
        for (int t = 1; t < 4; t += 2) begin
            wr(12'h008, 32'h100 | 32'(t));
            cmd(8'h28);
            wdp(1'b1);
            repeat (2) `PULSE(blk)
            `CHK("tdc_hold", 4, n_disc)
            finish_cmd();
        end
        // illegal control plus burst combination
        wr(12'h004, 32'h1);
        cmd(8'h08);
        tick(4);
        `CHK("check_cond", 1'b1, chk)
        `CHK("sense_key", 4'h5, skey)
        `CHK("sense_asc", 8'h26, sasc)
        `CHK("no_xfer", 1'b0, dphase)
        `PULSE(cdone)
        wr(12'h004, 32'h0);
        wr(12'h010, 32'h1);
        tick(2);
        `CHK("check_clear", 1'b0, chk)
        wr(12'h008, 32'h0);
        for (int i = 0; i < 5; i++) begin
            cmd(ops[i]);
            wdp(1'b1);
            finish_cmd();
        end
        cmd(8'h12);
        tick(5);
        `CHK("other_op", 1'b0, dphase)
        // mid-run reset returns configuration and outputs to zero
        wr(12'h008, 32'h170);
        rst <= 1'b1;
        tick(2);
        rst <= 1'b0;
        tick(2);
        `CHK("rst_fair", 1'b0, fair)
        apb(1'b0, 12'h008, 32'h0, rd, er);
        `CHK("rst_ctrl", 32'h0, rd)
        ztr <= 16'h0042;
        tick(1);
        apb(1'b0, 12'h018, 32'h0, rd, er);
        `CHK("zone_follow", 32'h00420056, rd)
        summarize();
    end
endmodule : scsi_target_disconnect_control_tb
`default_nettype wire
